// ### logic/multichannel_trigger_logic.sv
// Purpose: Multichannel level/edge trigger, pattern trigger, event flag, alarm
// Assumes: One scan strobe per complete set of samples; acqDone ends a record
// Notes:   Digital inputs are asynchronous and pass four flip-flops
`timescale 1ns/1ps
`include "mc_trig_consts.svh"

module multichannel_trigger_logic (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Scanned samples
  input  wire logic        scanStb,
  input  wire logic [15:0] scanSample [8],
  // Isolated digital inputs
  input  wire logic [15:0] digIn,
  // Acquisition side
  input  wire logic        acqDone,
  output logic             trigOut,
  output logic             recording,
  output logic             alarmRelay
);
  localparam int NCH = 8;

  logic [6:0]  ctrl_ff;
  logic [15:0] hyst_ff;
  logic [31:0] pat_ff;
  logic [31:0] chCfg_ff [NCH];
  logic [NCH-1:0] valid_ff, armed_ff, nxt_valid, nxt_armed;
  logic [15:0] s1_ff, s2_ff, s3_ff, din_ff;
  logic        prevMatch_ff, ev_ff, ack_ff, trig_ff, cond_ff, alarm_ff;
  logic [31:0] rdata_ff;
  mc_trig_pkg::acq_state_t state_ff, nxt_state;

  // Bus decode
  wire busReq   = read | write;
  wire acc      = busReq & ack_ff;
  wire wr       = write & ack_ff;
  wire isCh     = address >= `OFS_CH_BASE && address <= `OFS_CH_LAST
                  && address[1:0] == 2'h0;
  wire [2:0] chIx = 3'((address - `OFS_CH_BASE) >> 2);
  assign waitrequest = busReq & ~ack_ff;
  assign readdata    = rdata_ff;

  wire ready = state_ff == mc_trig_pkg::READY;
  wire andMd = ctrl_ff[`CTRL_AND];
  wire mcEn  = ctrl_ff[`CTRL_MC_EN];
  wire patEn = ctrl_ff[`CTRL_PAT_EN];
  wire neq   = ctrl_ff[`CTRL_NEQ];
  wire rearm = acqDone & (state_ff == mc_trig_pkg::BUSY);

  // Per-channel evaluation
  logic [NCH-1:0] chEn;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gCh
      wire [15:0] lvl  = chCfg_ff[g][15:0];
      wire [2:0]  typ  = chCfg_ff[g][`CH_TYPE_LSB +: 3];
      wire        edg  = typ[2];
      wire        lat  = typ[1];
      wire        neg  = typ[0];
      wire [16:0] hiS  = {1'b0, lvl} + {1'b0, hyst_ff};
      wire [15:0] lo   = (lvl > hyst_ff) ? 16'(lvl - hyst_ff) : 16'h0000;
      wire [15:0] hi   = hiS[16] ? 16'hFFFF : hiS[15:0];
      wire [15:0] smp  = scanSample[g];
      wire        hit  = neg ? (smp < lvl) : (smp > lvl);
      wire        band = neg ? (smp > hi) : (smp < lo);
      wire        setE = armed_ff[g] & hit;
      logic       v;
      assign chEn[g] = chCfg_ff[g][`CH_EN];
      always_comb begin
        v = valid_ff[g];
        if (!edg) begin
          v = lat ? (valid_ff[g] | hit) : hit;
        end else if (lat) begin
          v = valid_ff[g] | setE;
        end else begin
          v = band ? 1'b0 : (valid_ff[g] | setE);
        end
      end
      assign nxt_armed[g] = scanStb ? (armed_ff[g] | band) : armed_ff[g];
      assign nxt_valid[g] = scanStb ? v : valid_ff[g];
    end
  endgenerate

  wire [NCH-1:0] scanV = (scanStb ? nxt_valid : valid_ff) & chEn;
  wire andHit = (&(scanV | ~chEn)) & (|chEn);
  wire orHit  = |scanV;
  wire mcHit  = andMd ? andHit : orHit;

  wire [15:0] pMask = pat_ff[31:16];
  wire match  = ((din_ff ^ pat_ff[15:0]) & ~pMask) == 16'h0000;
  wire patHit = neq ? (prevMatch_ff & ~match) : match;

  wire fire = ready & ((scanStb & mcEn & mcHit) | (patEn & patHit));

  wire evNow = ctrl_ff[`CTRL_EVPAT] ? (match & ~prevMatch_ff) : (din_ff != s3_ff
               && s2_ff == s3_ff);
  wire evClr = wr && address == `OFS_STAT && writedata[`STAT_EVENT];

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      mc_trig_pkg::UNCFG: if (ctrl_ff[`CTRL_CFG]) nxt_state = mc_trig_pkg::READY;
      mc_trig_pkg::READY: begin
        if (!ctrl_ff[`CTRL_CFG]) nxt_state = mc_trig_pkg::UNCFG;
        else if (fire) nxt_state = mc_trig_pkg::BUSY;
      end
      mc_trig_pkg::BUSY: if (acqDone) nxt_state = mc_trig_pkg::UNCFG;
      default: nxt_state = mc_trig_pkg::UNCFG;
    endcase
  end

  wire [31:0] rdMux =
    (address == `OFS_CTRL) ? {25'h0, ctrl_ff} :
    (address == `OFS_HYST) ? {16'h0, hyst_ff} :
    (address == `OFS_PAT)  ? pat_ff :
    (address == `OFS_STAT) ? {din_ff, valid_ff, 5'h0, ev_ff,
                              state_ff == mc_trig_pkg::BUSY, ready} :
    isCh ? chCfg_ff[chIx] : 32'h0000_0000;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff   <= busReq & ~ack_ff;
      rdata_ff <= (read & ~ack_ff) ? rdMux : rdata_ff;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= `CTRL_RST;
      hyst_ff <= `HYST_RST;
      pat_ff  <= `PAT_RST;
    end else if (wr) begin
      if (address == `OFS_CTRL) ctrl_ff <= writedata[6:0];
      if (address == `OFS_HYST) hyst_ff <= writedata[15:0];
      if (address == `OFS_PAT)  pat_ff  <= writedata;
    end
  end

  generate
    for (g = 0; g < NCH; g++) begin : gCfg
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) chCfg_ff[g] <= `CH_RST;
        else if (wr && isCh && chIx == 3'(g)) chCfg_ff[g] <= writedata;
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff  <= 16'h0000;
      s2_ff  <= 16'h0000;
      s3_ff  <= 16'h0000;
      din_ff <= 16'h0000;
    end else begin
      s1_ff  <= digIn;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      din_ff <= (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & din_ff);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      valid_ff     <= '0;
      armed_ff     <= '0;
      state_ff     <= mc_trig_pkg::UNCFG;
      prevMatch_ff <= 1'b0;
      ev_ff        <= 1'b0;
      trig_ff      <= 1'b0;
      cond_ff      <= 1'b0;
      alarm_ff     <= 1'b0;
    end else begin
      valid_ff     <= rearm ? '0 : nxt_valid;
      armed_ff     <= rearm ? '0 : nxt_armed;
      state_ff     <= nxt_state;
      prevMatch_ff <= match;
      // Set wins over clear
      ev_ff        <= evNow | (ev_ff & ~evClr);
      trig_ff      <= fire;
      cond_ff      <= (mcEn & mcHit) | (patEn & match);
      alarm_ff     <= ctrl_ff[`CTRL_ALARM] & cond_ff &
                      (state_ff == mc_trig_pkg::BUSY);
    end
  end

  assign trigOut    = trig_ff;
  assign recording  = state_ff == mc_trig_pkg::BUSY;
  assign alarmRelay = alarm_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_trig_ready_only: assert property (
    trigOut |-> $past(state_ff) == mc_trig_pkg::READY)
    else $error("trigger fired while not ready");
  a_no_flag_ignore: assert property (
    (fire == 1'b0) |=> !trigOut)
    else $error("trigger pulse without fire");
  a_or_fire: assert property (
    ready && scanStb && mcEn && !andMd && orHit |=> trigOut)
    else $error("OR mode missed a valid channel");
  a_and_block: assert property (
    trigOut && $past(andMd) && !$past(patEn) |-> $past(andHit))
    else $error("AND mode fired with invalid channel");
  a_latch_hold: assert property (
    valid_ff[0] && chCfg_ff[0][25] && !rearm |=> valid_ff[0])
    else $error("latched channel lost validity");
  a_edge_init: assert property (
    chCfg_ff[0][26] && !armed_ff[0] && !(scanStb && gCh[0].band)
    |=> !valid_ff[0])
    else $error("edge channel valid without arming");
  a_pat_mask: assert property (
    neq == 1'b0 && patEn && ready && match |=> trigOut)
    else $error("equal pattern did not fire");
  a_alarm_busy: assert property (
    alarmRelay |-> $past(recording))
    else $error("alarm outside recording");
  a_bus_wait: assert property (
    busReq && !ack_ff |=> !waitrequest)
    else $error("bus stalled more than one cycle");

  // Channel evaluation checks

  a_above_set: assert property (
    scanStb && !rearm && chCfg_ff[0][26:24] == 3'h0 && scanSample[0] > chCfg_ff[0][15:0]
    |=> valid_ff[0])
    else $error("above-level channel not valid");

  a_above_clear: assert property (
    scanStb && !rearm && chCfg_ff[0][26:24] == 3'h0 && scanSample[0] < chCfg_ff[0][15:0]
    |=> !valid_ff[0])
    else $error("above-level channel stayed valid");

  a_below_set: assert property (
    scanStb && !rearm && chCfg_ff[1][26:24] == 3'h1 && scanSample[1] < chCfg_ff[1][15:0]
    |=> valid_ff[1])
    else $error("below-level channel not valid");

  a_below_clear: assert property (
    scanStb && !rearm && chCfg_ff[1][26:24] == 3'h1 && scanSample[1] > chCfg_ff[1][15:0]
    |=> !valid_ff[1])
    else $error("below-level channel stayed valid");

  a_latch_below: assert property (
    valid_ff[1] && chCfg_ff[1][26:24] == 3'h3 && !rearm |=> valid_ff[1])
    else $error("latched below channel lost validity");

  a_rise_clear: assert property (
    scanStb && !rearm && chCfg_ff[0][26:24] == 3'h4 && scanSample[0] < gCh[0].lo
    |=> !valid_ff[0])
    else $error("rising edge channel valid below band");

  a_fall_clear: assert property (
    scanStb && !rearm && chCfg_ff[0][26:24] == 3'h5 && scanSample[0] > gCh[0].hi
    |=> !valid_ff[0])
    else $error("falling edge channel valid above band");

  a_rise_latch: assert property (
    valid_ff[0] && chCfg_ff[0][26:24] == 3'h6 && !rearm |=> valid_ff[0])
    else $error("latched rising edge lost validity");

  a_fall_latch: assert property (
    valid_ff[1] && chCfg_ff[1][26:24] == 3'h7 && !rearm |=> valid_ff[1])
    else $error("latched falling edge lost validity");

  a_rearm_clear: assert property (
    rearm |=> valid_ff == 8'h00 && armed_ff == 8'h00)
    else $error("re-arm left channel state set");

  // Combining checks

  a_stable_no_scan: assert property (
    !scanStb && !rearm |=> $stable(valid_ff))
    else $error("channel state changed outside a scan");

  a_or_cause: assert property (
    trigOut && !$past(andMd) && !$past(patEn) |-> $past(orHit))
    else $error("OR mode fired with no valid channel");

  a_and_empty: assert property (
    chEn == 8'h00 |-> !andHit)
    else $error("AND mode hit with no channel enabled");

  a_and_lost: assert property (
    ready && scanStb && mcEn && andMd && !patEn && (nxt_valid & chEn) != chEn
    |=> !trigOut)
    else $error("AND mode fired with a lost channel");

  // Pattern and input checks

  a_pat_equal_miss: assert property (
    patEn && !neq && !mcEn && !match |=> !trigOut)
    else $error("equal pattern fired without match");

  a_neq_fire: assert property (
    ready && patEn && neq && prevMatch_ff && !match |=> trigOut)
    else $error("not-equal pattern missed a lost match");

  a_mask_ignore: assert property (
    pat_ff[31:16] == 16'hFFFF |-> match)
    else $error("fully masked pattern did not match");

  a_sync_agree: assert property (
    $changed(din_ff) |-> $past(s2_ff) == $past(s3_ff))
    else $error("input accepted before stages agreed");

  a_event_set: assert property (
    evNow |=> ev_ff)
    else $error("input event not flagged");

  // Readiness and alarm checks

  a_alarm_on: assert property (
    ctrl_ff[`CTRL_ALARM] && cond_ff && recording |=> alarmRelay)
    else $error("alarm not energised while recording");

  a_busy_block: assert property (
    recording |=> !trigOut)
    else $error("trigger accepted while recording");

  a_no_source: assert property (
    !mcEn && !patEn |=> !trigOut)
    else $error("trigger with every source disabled");

  c_or_trig:  cover property (!andMd && trigOut);
  c_and_trig: cover property (andMd && mcEn && trigOut);
  c_pat_neq:  cover property (neq && patEn && trigOut);
  c_alarm:    cover property (alarmRelay);
  c_rise_trig: cover property (chCfg_ff[0][26:24] == 3'h4 && trigOut);
endmodule : multichannel_trigger_logic

// ### logic/mc_trig_consts.svh
// Purpose: Offsets, field positions and reset values of the trigger block
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes:   Channel config words sit at CH_BASE + 4*channel
`ifndef MC_TRIG_CONSTS_SVH
`define MC_TRIG_CONSTS_SVH
`define OFS_CTRL     8'h00
`define OFS_HYST     8'h04
`define OFS_PAT      8'h08
`define OFS_STAT     8'h0C
`define OFS_CH_BASE  8'h10
`define OFS_CH_LAST  8'h2C
`define CTRL_CFG     0
`define CTRL_AND     1
`define CTRL_MC_EN   2
`define CTRL_PAT_EN  3
`define CTRL_NEQ     4
`define CTRL_ALARM   5
`define CTRL_EVPAT   6
`define STAT_EVENT   2
`define CH_TYPE_LSB  24
`define CH_EN        27
`define CTRL_RST     7'h00
`define HYST_RST     16'h0000
`define PAT_RST      32'h0000_0000
`define CH_RST       32'h0000_0000
`endif

// ### logic/mc_trig_pkg.sv
// Purpose: Types of the trigger block
// Assumes: Constants live in mc_trig_consts.svh
// Notes:   Type code order gives edge=bit2, latch=bit1, falling=bit0
package mc_trig_pkg;
  typedef enum logic [2:0] {
    ABOVE, BELOW, ABOVE_L, BELOW_L, RISE, FALL, RISE_L, FALL_L
  } trig_type_t;
  typedef enum logic [1:0] {UNCFG, READY, BUSY} acq_state_t;
endpackage : mc_trig_pkg

// ### tb/scan_source.sv
// Purpose: Scan source and isolated digital input model
// Assumes: One strobe per requested scan, samples valid with it
// Notes:   Samples invert outside the strobe cycle
`timescale 1ns/1ps
module scan_source (
  // Clock
  input  wire logic        core_clk,
  // Bench side
  input  wire logic        scanReq,
  input  wire logic [15:0] level [8],
  input  wire logic [15:0] digLevel,
  // Block side
  output logic             scanStb,
  output logic      [15:0] scanSample [8],
  output logic      [15:0] digIn
);
  initial begin
    scanStb = 1'b0;
    digIn = 16'h0000;
    foreach (scanSample[i]) scanSample[i] = 16'h0000;
  end
  always @(posedge core_clk) begin
    scanStb <= scanReq;
    digIn <= digLevel;
    foreach (scanSample[i]) scanSample[i] <= scanReq ? level[i] : ~scanSample[i];
  end
endmodule : scan_source

// ### tb/multichannel_trigger_logic_bench.sv
// Purpose: Self-checking bench of the trigger block
// Assumes: One wait state on every bus access
// Notes:   Channels 2..7 stay disabled
`timescale 1ns/1ps
`include "mc_trig_consts.svh"
module multichannel_trigger_logic_bench;
  logic        core_clk, arst_n, read, write, scanStb, scanReq, acqDone;
  logic        waitrequest, trigOut, recording, alarmRelay;
  logic [7:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic [15:0] lv [8];
  logic [15:0] scanSample [8];
  logic [15:0] digIn, dl;
  int          fails, compares, cycles;

  multichannel_trigger_logic multichannel_trigger_logic_inst (
    .core_clk(core_clk), .arst_n(arst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .scanStb(scanStb), .scanSample(scanSample),
    .digIn(digIn), .acqDone(acqDone), .trigOut(trigOut), .recording(recording),
    .alarmRelay(alarmRelay));
  scan_source scan_source_inst (.core_clk(core_clk), .scanReq(scanReq), .level(lv),
    .digLevel(dl), .scanStb(scanStb), .scanSample(scanSample), .digIn(digIn));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report;
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // Holds the request until waitrequest is sampled low
  task automatic busOp(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    @(posedge core_clk);
    read <= ~wr;
    write <= wr;
    address <= adr;
    writedata <= wd;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : busOp

  task automatic rdChk(input string n, input logic [7:0] a, input logic [31:0] e, m);
    busOp(1'b0, a, 32'h0000_0000);
    check(n, rd & m, e);
  endtask : rdChk

  task automatic scan(input logic [15:0] s0, s1, input logic e);
    @(posedge core_clk);
    scanReq <= 1'b1;
    lv[0] <= s0;
    lv[1] <= s1;
    @(posedge core_clk);
    scanReq <= 1'b0;
    @(posedge core_clk);
    #1 check("trigOut", {31'h0, trigOut}, {31'h0, e});
  endtask : scan

  task automatic patTrig(input logic [15:0] d, input logic e);
    logic got;
    got = 1'b0;
    @(posedge core_clk);
    dl <= d;
    repeat (10) begin
      @(posedge core_clk);
      #1 got = got | (trigOut === 1'b1);
    end
    check("patTrig", {31'h0, got}, {31'h0, e});
  endtask : patTrig

  task automatic endAcq;
    @(posedge core_clk);
    acqDone <= 1'b1;
    @(posedge core_clk);
    acqDone <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 check("recording", {31'h0, recording}, 32'h0000_0000);
  endtask : endAcq

  function automatic logic [31:0] chWord(input mc_trig_pkg::trig_type_t t, input logic [15:0] l);
    return {4'h0, 1'b1, t, 8'h00, l};
  endfunction : chWord

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    {arst_n, read, write, scanReq, acqDone} = 5'h00;
    address = 8'h00;
    writedata = 32'h0000_0000;
    dl = 16'h0000;
    foreach (lv[i]) lv[i] = 16'h0000;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    rdChk("ctrlRst", `OFS_CTRL, 32'h0000_0000, 32'h0000_007F);
    busOp(1'b1, 8'h30, 32'hFFFF_FFFF);
    rdChk("unmapped", 8'h30, 32'h0000_0000, 32'hFFFF_FFFF);
    busOp(1'b1, `OFS_CH_BASE, chWord(mc_trig_pkg::ABOVE, 16'h1000));
    busOp(1'b1, `OFS_CTRL, 32'h0000_0025);
    rdChk("ctrl", `OFS_CTRL, 32'h0000_0025, 32'h0000_007F);
    scan(16'h1000, 16'h0000, 1'b0);
    scan(16'h1001, 16'h0000, 1'b1);
    @(posedge core_clk);
    #1 check("alarm", {31'h0, alarmRelay}, 32'h0000_0001);
    rdChk("stat", `OFS_STAT, 32'h0000_0002, 32'h0000_0003);
    scan(16'h2000, 16'h0000, 1'b0);
    endAcq();
    check("alarmOff", {31'h0, alarmRelay}, 32'h0000_0000);
    busOp(1'b1, `OFS_CH_BASE + 8'h04, chWord(mc_trig_pkg::BELOW_L, 16'h0800));
    busOp(1'b1, `OFS_CTRL, 32'h0000_0007);
    scan(16'h1001, 16'h0900, 1'b0);
    scan(16'h0F00, 16'h0700, 1'b0);
    scan(16'h1001, 16'h0900, 1'b1);
    endAcq();
    busOp(1'b1, `OFS_CH_BASE + 8'h04, 32'h0000_0000);
    busOp(1'b1, `OFS_HYST, 32'h0000_0100);
    busOp(1'b1, `OFS_CH_BASE, chWord(mc_trig_pkg::RISE, 16'h1000));
    busOp(1'b1, `OFS_CTRL, 32'h0000_0005);
    scan(16'h2000, 16'h0000, 1'b0);
    scan(16'h0F80, 16'h0000, 1'b0);
    scan(16'h2000, 16'h0000, 1'b0);
    scan(16'h0E00, 16'h0000, 1'b0);
    scan(16'h1001, 16'h0000, 1'b1);
    endAcq();
    busOp(1'b1, `OFS_CH_BASE, 32'h0000_0000);
    busOp(1'b1, `OFS_PAT, 32'hFF00_00A5);
    busOp(1'b1, `OFS_CTRL, 32'h0000_0009);
    patTrig(16'h12A4, 1'b0);
    patTrig(16'h34A5, 1'b1);
    patTrig(16'h0000, 1'b0);
    endAcq();
    busOp(1'b1, `OFS_CTRL, 32'h0000_0019);
    patTrig(16'h00A5, 1'b0);
    patTrig(16'hFFA5, 1'b0);
    patTrig(16'hFFA7, 1'b1);
    rdChk("event", `OFS_STAT, 32'h0000_0004, 32'h0000_0004);
    busOp(1'b1, `OFS_STAT, 32'h0000_0004);
    rdChk("evClr", `OFS_STAT, 32'h0000_0000, 32'h0000_0004);
    final_report();
  end
endmodule : multichannel_trigger_logic_bench
